// ==== crb_pkg.sv ====
// constants, types and state codes for the configuration load and readback block
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - rising readback trigger arms; in-progress rises at next shift clock rise
// - each later shift clock rise presents the next readback bit
// - no preamble: five high dummy bits, then low start bit of frame one
// - first two data bits of the first frame always read high
// - every frame closes with four check bit positions reading high
// - last seven data bits of the last frame read high
// - after last frame: low start bit, 11-bit crc, then in-progress falls
// - readback leaves operation alone; may report storage and ram state
// - configuration bits return with load polarity, never inverted
// - wide fast load designs read back in normal layout, unlike load stream
// - each tck rise while scan load is active and clear status is high counts toward the length tally
// - sync mode takes first byte on second config clock rise after clear high
// - sync mode takes each later byte every eighth config clock rise
// - sync mode ack is high one config clock period after each capture
// - loaded byte shifts out half a config clock period after parallel load
// - async busy lasts 2 to 8 config clock periods while buffer is full
// - busy shortest into empty converter, longest when converter just loaded with all eight bits left
package crb_pkg;

  //----------------------------------------------------------------------------
  // readback stream layout
  //----------------------------------------------------------------------------
  localparam int unsigned DUMMY_BITS = 5;
  localparam int unsigned CHECK_BITS = 4;
  localparam int unsigned LEAD_HIGH_BITS = 2;
  localparam int unsigned TAIL_HIGH_BITS = 7;
  localparam int unsigned CRC_BITS = 11;
  localparam logic [3:0] DUMMY_LAST = 4'(DUMMY_BITS - 1);
  localparam logic [3:0] CHECK_LAST = 4'(CHECK_BITS - 1);
  localparam logic [3:0] CRC_LAST = 4'(CRC_BITS - 1);

  //----------------------------------------------------------------------------
  // parallel load timing
  //----------------------------------------------------------------------------
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned SYNC_FIRST_EDGE = 2;
  localparam int unsigned SYNC_BYTE_EDGES = 8;
  localparam logic [2:0] SYNC_LEAD = 3'(SYNC_FIRST_EDGE - 1);
  localparam logic [2:0] SYNC_RELOAD = 3'(SYNC_BYTE_EDGES - 1);
  localparam logic [3:0] SHIFT_FULL = 4'(BYTE_BITS);

  //----------------------------------------------------------------------------
  // types
  //----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    RB_IDLE  = 4'h0,
    RB_ARM   = 4'h1,
    RB_DUMMY = 4'h2,
    RB_START = 4'h3,
    RB_DATA  = 4'h4,
    RB_CHECK = 4'h5,
    RB_FINAL = 4'h6,
    RB_CRC   = 4'h7,
    RB_END   = 4'h8
  } crb_rb_state_t;

  typedef enum logic [1:0] {
    MODE_NONE  = 2'h0,
    MODE_SYNC  = 2'h1,
    MODE_ASYNC = 2'h2
  } crb_mode_t;

  typedef struct packed {
    logic chipSelectLowActive;
    logic writeStrobe;
    logic readStrobe;
    logic chipSelectHighActive;
  } crb_strobe_t;

  typedef struct packed {
    logic trig;
    logic shiftClk;
    logic cfgClk;
    logic clearN;
    crb_mode_t mode;
    logic [BYTE_BITS-1:0] data;
    crb_strobe_t strobes;
    logic tck;
    logic tdi;
    logic scanLoad;
  } crb_pins_t;

endpackage

// ==== crb_config_load.sv ====
// configuration load ports and serial readback engine
`timescale 1ns/10ps
module crb_config_load #(
  parameter int unsigned FRAME_BITS = 16,
  parameter int unsigned FRAME_COUNT = 4,
  parameter int unsigned FW = 8,
  parameter int unsigned BW = 12,
  parameter int unsigned LW = 24,
  parameter logic [crb_pkg::CRC_BITS-1:0] CRC_POLY = 11'h005
) (
  input logic clk,
  input logic arst_n,
  input logic readbackTrigger,
  input logic readbackShiftClock,
  input logic readbackDataBit,
  output logic [FW-1:0] readbackFrameIndex,
  output logic [BW-1:0] readbackBitIndex,
  output logic readbackInProgress,
  output logic readbackSerialOut,
  input logic configClock,
  input logic configClearStatusN,
  input crb_pkg::crb_mode_t peripheralMode,
  input logic [crb_pkg::BYTE_BITS-1:0] parallelByte,
  input crb_pkg::crb_strobe_t periphStrobes,
  output logic handshakeAck,
  output logic serialChainOut,
  input logic tck,
  input logic tdi,
  input logic scanLoadActive,
  input logic [LW-1:0] frameLengthTarget,
  output logic [LW-1:0] frameLengthTally,
  output logic lengthReached,
  output logic jtagBit,
  output logic jtagBitValid
);
  import crb_pkg::*;

  localparam logic [BW-1:0] BIT_LAST = BW'(FRAME_BITS - 1);
  localparam logic [BW-1:0] LEAD_END = BW'(LEAD_HIGH_BITS);
  localparam logic [BW-1:0] TAIL_START = BW'(FRAME_BITS - TAIL_HIGH_BITS);
  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_COUNT - 1);

  function automatic logic [CRC_BITS-1:0] crcStep(input logic [CRC_BITS-1:0] c, input logic b);
    logic fb;
    fb = c[CRC_BITS-1] ^ b;
    crcStep = {c[CRC_BITS-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
  endfunction

  //----------------------------------------------------------------------------
  // pin synchronisers and edge finders
  //----------------------------------------------------------------------------
  crb_pins_t pinsRaw;
  crb_pins_t pinsMeta;
  crb_pins_t pinsSync;
  crb_pins_t pinsPrev;

  assign pinsRaw = {readbackTrigger, readbackShiftClock, configClock, configClearStatusN,
                    peripheralMode, parallelByte, periphStrobes, tck, tdi, scanLoadActive};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinsMeta <= '0;
      pinsSync <= '0;
      pinsPrev <= '0;
    end else begin
      pinsMeta <= pinsRaw;
      pinsSync <= pinsMeta;
      pinsPrev <= pinsSync;
    end
  end

  logic trigRise;
  logic shiftRise;
  logic cclkRise;
  logic cclkFall;
  logic clearRise;
  logic tckRise;
  assign trigRise = pinsSync.trig & ~pinsPrev.trig;
  assign shiftRise = pinsSync.shiftClk & ~pinsPrev.shiftClk;
  assign cclkRise = pinsSync.cfgClk & ~pinsPrev.cfgClk;
  assign cclkFall = ~pinsSync.cfgClk & pinsPrev.cfgClk;
  assign clearRise = pinsSync.clearN & ~pinsPrev.clearN;
  assign tckRise = pinsSync.tck & ~pinsPrev.tck;

  //----------------------------------------------------------------------------
  // readback sequencer
  //----------------------------------------------------------------------------
  // the engine only reads storage through the index ports, so user logic runs on
  // stream layout is the same whatever mode the design was loaded
  crb_rb_state_t rbState;
  crb_rb_state_t next_rbState;
  logic [3:0] rbCnt;
  logic [3:0] next_rbCnt;
  logic [CRC_BITS-1:0] rbCrc;
  logic [CRC_BITS-1:0] next_rbCrc;
  logic [CRC_BITS-1:0] rbCrcShift;
  logic [CRC_BITS-1:0] next_rbCrcShift;
  logic [FW-1:0] next_readbackFrameIndex;
  logic [BW-1:0] next_readbackBitIndex;
  logic next_readbackInProgress;
  logic next_readbackSerialOut;
  logic forcedHigh;
  logic rbData;

  assign forcedHigh = (readbackFrameIndex == '0 && readbackBitIndex < LEAD_END) ||
                      (readbackFrameIndex == FRAME_LAST &&
                       readbackBitIndex >= TAIL_START);
  assign rbData = forcedHigh | readbackDataBit;

  always_comb begin
    next_rbState = rbState;
    next_rbCnt = rbCnt;
    next_rbCrc = rbCrc;
    next_rbCrcShift = rbCrcShift;
    next_readbackFrameIndex = readbackFrameIndex;
    next_readbackBitIndex = readbackBitIndex;
    next_readbackInProgress = readbackInProgress;
    next_readbackSerialOut = readbackSerialOut;
    if (rbState == RB_IDLE) begin
      if (trigRise) begin
        next_rbState = RB_ARM;
      end
    end else if (shiftRise) begin
      case (rbState)
        RB_ARM: begin
          next_readbackInProgress = 1'b1;
          next_rbState = RB_DUMMY;
          next_rbCnt = '0;
          next_rbCrc = '0;
        end
        RB_DUMMY: begin
          next_readbackSerialOut = 1'b1;
          if (rbCnt == DUMMY_LAST) begin
            next_rbState = RB_START;
          end else begin
            next_rbCnt = rbCnt + 4'h1;
          end
        end
        RB_START: begin
          next_readbackSerialOut = 1'b0;
          next_rbState = RB_DATA;
          next_readbackBitIndex = '0;
        end
        RB_DATA: begin
          next_readbackSerialOut = rbData;
          next_rbCrc = crcStep(rbCrc, rbData);
          if (readbackBitIndex == BIT_LAST) begin
            next_rbState = RB_CHECK;
            next_rbCnt = '0;
          end else begin
            next_readbackBitIndex = readbackBitIndex + BW'(1);
          end
        end
        RB_CHECK: begin
          next_readbackSerialOut = 1'b1;
          if (rbCnt != CHECK_LAST) begin
            next_rbCnt = rbCnt + 4'h1;
          end else if (readbackFrameIndex == FRAME_LAST) begin
            next_rbState = RB_FINAL;
          end else begin
            next_readbackFrameIndex = readbackFrameIndex + FW'(1);
            next_rbState = RB_START;
          end
        end
        RB_FINAL: begin
          next_readbackSerialOut = 1'b0;
          next_rbCrcShift = rbCrc;
          next_rbCnt = '0;
          next_rbState = RB_CRC;
        end
        RB_CRC: begin
          next_readbackSerialOut = rbCrcShift[CRC_BITS-1];
          next_rbCrcShift = {rbCrcShift[CRC_BITS-2:0], 1'b0};
          if (rbCnt == CRC_LAST) begin
            next_rbState = RB_END;
          end else begin
            next_rbCnt = rbCnt + 4'h1;
          end
        end
        RB_END: begin
          next_readbackInProgress = 1'b0;
          next_readbackSerialOut = 1'b1;
          next_readbackFrameIndex = '0;
          next_readbackBitIndex = '0;
          next_rbState = RB_IDLE;
        end
        default: begin
          next_rbState = RB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rbState <= RB_IDLE;
      rbCnt <= '0;
      rbCrc <= '0;
      rbCrcShift <= '0;
      readbackFrameIndex <= '0;
      readbackBitIndex <= '0;
      readbackInProgress <= 1'b0;
      readbackSerialOut <= 1'b1;
    end else begin
      rbState <= next_rbState;
      rbCnt <= next_rbCnt;
      rbCrc <= next_rbCrc;
      rbCrcShift <= next_rbCrcShift;
      readbackFrameIndex <= next_readbackFrameIndex;
      readbackBitIndex <= next_readbackBitIndex;
      readbackInProgress <= next_readbackInProgress;
      readbackSerialOut <= next_readbackSerialOut;
    end
  end

  //----------------------------------------------------------------------------
  // peripheral byte load and parallel-to-serial converter
  //----------------------------------------------------------------------------
  logic [2:0] syncCnt;
  logic [2:0] next_syncCnt;
  logic syncArmed;
  logic next_syncArmed;
  logic [BYTE_BITS-1:0] inputReg;
  logic [BYTE_BITS-1:0] next_inputReg;
  logic inputFull;
  logic next_inputFull;
  logic inputArm;
  logic next_inputArm;
  logic [BYTE_BITS-1:0] shiftReg;
  logic [BYTE_BITS-1:0] next_shiftReg;
  logic [3:0] bitsLeft;
  logic [3:0] next_bitsLeft;
  logic writeOn;
  logic writePrev;
  logic next_handshakeAck;
  logic next_serialChainOut;
  logic syncCapture;
  logic loadShift;
  logic [BYTE_BITS-1:0] loadByte;

  assign writeOn = ~pinsSync.strobes.chipSelectLowActive & ~pinsSync.strobes.writeStrobe &
                   pinsSync.strobes.readStrobe & pinsSync.strobes.chipSelectHighActive;

  always_comb begin
    next_syncCnt = syncCnt;
    next_syncArmed = syncArmed;
    next_inputReg = inputReg;
    next_inputFull = inputFull;
    next_inputArm = inputArm;
    next_shiftReg = shiftReg;
    next_bitsLeft = bitsLeft;
    next_handshakeAck = handshakeAck;
    next_serialChainOut = serialChainOut;
    syncCapture = 1'b0;
    loadShift = 1'b0;
    loadByte = '0;
    case (pinsSync.mode)
      MODE_SYNC: begin
        if (!pinsSync.clearN) begin
          next_syncArmed = 1'b0;
        end else if (clearRise) begin
          next_syncArmed = 1'b1;
          next_syncCnt = SYNC_LEAD;
        end else if (cclkRise && syncArmed) begin
          if (syncCnt == '0) begin
            syncCapture = 1'b1;
            next_syncCnt = SYNC_RELOAD;
          end else begin
            next_syncCnt = syncCnt - 3'h1;
          end
        end
        if (syncCapture) begin
          loadShift = 1'b1;
          loadByte = pinsSync.data;
          next_handshakeAck = 1'b1;
        end else if (cclkRise) begin
          next_handshakeAck = 1'b0;
        end
      end
      MODE_ASYNC: begin
        // byte is taken just after the end of the write, so data must outlast it
        if (writePrev && !writeOn && !inputFull) begin
          next_inputReg = pinsSync.data;
          next_inputFull = 1'b1;
          next_inputArm = 1'b0;
        end else if (cclkRise && inputFull) begin
          if (!inputArm) begin
            next_inputArm = 1'b1;
          end else if (bitsLeft == '0) begin
            loadShift = 1'b1;
            loadByte = inputReg;
            next_inputFull = 1'b0;
            next_inputArm = 1'b0;
          end
        end
        next_handshakeAck = ~next_inputFull;
      end
      default: begin
        next_syncArmed = 1'b0;
        next_inputFull = 1'b0;
        next_inputArm = 1'b0;
        next_handshakeAck = 1'b0;
      end
    endcase
    if (loadShift) begin
      next_shiftReg = loadByte;
      next_bitsLeft = SHIFT_FULL;
    end else if (cclkFall && bitsLeft != '0) begin
      next_serialChainOut = shiftReg[BYTE_BITS-1];
      next_shiftReg = {shiftReg[BYTE_BITS-2:0], 1'b0};
      next_bitsLeft = bitsLeft - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncCnt <= '0;
      syncArmed <= 1'b0;
      inputReg <= '0;
      inputFull <= 1'b0;
      inputArm <= 1'b0;
      shiftReg <= '0;
      bitsLeft <= '0;
      writePrev <= 1'b0;
      handshakeAck <= 1'b0;
      serialChainOut <= 1'b1;
    end else begin
      syncCnt <= next_syncCnt;
      syncArmed <= next_syncArmed;
      inputReg <= next_inputReg;
      inputFull <= next_inputFull;
      inputArm <= next_inputArm;
      shiftReg <= next_shiftReg;
      bitsLeft <= next_bitsLeft;
      writePrev <= writeOn;
      handshakeAck <= next_handshakeAck;
      serialChainOut <= next_serialChainOut;
    end
  end

  //----------------------------------------------------------------------------
  // test port load and length tally
  //----------------------------------------------------------------------------
  logic [LW-1:0] next_frameLengthTally;
  logic next_lengthReached;
  logic next_jtagBit;
  logic next_jtagBitValid;

  always_comb begin
    next_frameLengthTally = frameLengthTally;
    next_jtagBit = jtagBit;
    next_jtagBitValid = 1'b0;
    if (!pinsSync.clearN) begin
      next_frameLengthTally = '0;
    end else if (pinsSync.scanLoad && tckRise) begin
      next_frameLengthTally = frameLengthTally + LW'(1);
      next_jtagBit = pinsSync.tdi;
      next_jtagBitValid = 1'b1;
    end
    next_lengthReached = (next_frameLengthTally >= frameLengthTarget) && pinsSync.clearN;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frameLengthTally <= '0;
      lengthReached <= 1'b0;
      jtagBit <= 1'b0;
      jtagBitValid <= 1'b0;
    end else begin
      frameLengthTally <= next_frameLengthTally;
      lengthReached <= next_lengthReached;
      jtagBit <= next_jtagBit;
      jtagBitValid <= next_jtagBitValid;
    end
  end

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rip_rise: assert property ($rose(readbackInProgress) |-> $past(shiftRise) &&
                               $past(rbState) == RB_ARM)
    else $error("in-progress rose without armed shift edge");
  a_rb_step: assert property ($changed(readbackSerialOut) |-> $past(shiftRise))
    else $error("readback bit moved off a shift edge");
  a_dummy_high: assert property (rbState == RB_DUMMY && shiftRise |=> readbackSerialOut)
    else $error("dummy bit not high");
  a_start_low: assert property (rbState == RB_START && shiftRise |=> !readbackSerialOut)
    else $error("start bit not low");
  a_lead_high: assert property (rbState == RB_DATA && shiftRise &&
                                readbackFrameIndex == '0 && readbackBitIndex < LEAD_END |=>
                                readbackSerialOut)
    else $error("leading data bit not high");
  a_check_high: assert property (rbState == RB_CHECK && shiftRise |=> readbackSerialOut)
    else $error("check bit not high");
  a_tail_high: assert property (rbState == RB_DATA && shiftRise &&
                                readbackFrameIndex == FRAME_LAST &&
                                readbackBitIndex >= TAIL_START |=> readbackSerialOut)
    else $error("trailing data bit not high");
  a_rip_fall: assert property ($fell(readbackInProgress) |-> $past(rbState) == RB_END)
    else $error("in-progress fell before crc end");
  a_data_pass: assert property (rbState == RB_DATA && shiftRise && !forcedHigh |=>
                                readbackSerialOut == $past(readbackDataBit))
    else $error("readback data altered");
  a_ack_period: assert property (pinsSync.mode == MODE_SYNC && $fell(handshakeAck) |->
                                 $past(cclkRise))
    else $error("sync ack dropped off a clock edge");
  a_busy_floor: assert property (loadShift && pinsSync.mode == MODE_ASYNC |-> inputArm)
    else $error("async busy shorter than two clocks");
  a_shift_half: assert property ($changed(serialChainOut) |-> $past(cclkFall))
    else $error("serial out moved off falling edge");
  a_tally_step: assert property (pinsSync.clearN && pinsSync.scanLoad && tckRise |=>
                                 frameLengthTally == $past(frameLengthTally) + LW'(1))
    else $error("tck edge not counted");

endmodule

// ==== crb_storage_model.sv ====
// storage model that feeds stored configuration bits to the readback engine
`timescale 1ns/10ps
module crb_storage_model (
  input wire logic [7:0] frameIndex,
  input wire logic [11:0] bitIndex,
  output logic dataBit
);
  //----------------------------------------------------------------------------
  // stored bits
  //----------------------------------------------------------------------------
  // bits return exactly as stored, with no inversion on the way
  assign dataBit = frameIndex[0] ^ bitIndex[0] ^ bitIndex[2];
endmodule

// ==== tb.sv ====
// self-checking bench for the configuration load and readback block
`timescale 1ns/10ps
module tb;
  import crb_pkg::*;
  localparam int FB = 16;
  localparam int FC = 4;
  localparam logic [10:0] POLY = 11'h005;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic trig = 1'b0;
  logic rsc = 1'b0;
  logic config_clock = 1'b0;
  logic clearN = 1'b0;
  logic tck = 1'b0;
  logic tdi = 1'b0;
  logic scanLoadActive = 1'b0;
  logic rbData;
  logic [7:0] frameIdx;
  logic [11:0] bitIdx;
  logic readbackInProgress, readbackSerialOut, handshakeAck, serialChainOut;
  logic lengthReached, jtagBit, jtagBitValid;
  int validSeen = 0;
  logic [23:0] frameLengthTarget = 24'h000000;
  logic [23:0] frameLengthTally;
  crb_mode_t peripheralMode = MODE_NONE;
  logic [7:0] parallelByte = 8'h00;
  crb_strobe_t periphStrobes = '{1'b1, 1'b1, 1'b1, 1'b0};
  int mismatches = 0;
  int compares = 0;

  always #20 clk = ~clk;

  // counts one-clock valid pulses from the test port
  always @(negedge clk) begin
    if (jtagBitValid === 1'b1) validSeen++;
  end

  crb_config_load #(.FRAME_BITS(FB), .FRAME_COUNT(FC), .CRC_POLY(POLY)) u_crb_config_load (
    .clk(clk),
    .arst_n(arst_n),
    .readbackTrigger(trig),
    .readbackShiftClock(rsc),
    .readbackDataBit(rbData),
    .readbackFrameIndex(frameIdx),
    .readbackBitIndex(bitIdx),
    .readbackInProgress(readbackInProgress),
    .readbackSerialOut(readbackSerialOut),
    .configClock(config_clock),
    .configClearStatusN(clearN),
    .peripheralMode(peripheralMode),
    .parallelByte(parallelByte),
    .periphStrobes(periphStrobes),
    .handshakeAck(handshakeAck),
    .serialChainOut(serialChainOut),
    .tck(tck),
    .tdi(tdi),
    .scanLoadActive(scanLoadActive),
    .frameLengthTarget(frameLengthTarget),
    .frameLengthTally(frameLengthTally),
    .lengthReached(lengthReached),
    .jtagBit(jtagBit),
    .jtagBitValid(jtagBitValid)
  );

  crb_storage_model u_crb_storage_model (
    .frameIndex(frameIdx),
    .bitIndex(bitIdx),
    .dataBit(rbData)
  );

  //----------------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------------
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one pulse on the selected outside clock: 0 shift, 1 config, 2 tck
  task automatic pulse(input int sel, input int half);
    case (sel)
      0: rsc = 1'b1;
      1: config_clock = 1'b1;
      default: tck = 1'b1;
    endcase
    repeat (half) @(negedge clk);
    rsc = 1'b0;
    config_clock = 1'b0;
    tck = 1'b0;
    repeat (half) @(negedge clk);
  endtask

  task automatic write_byte(input logic [7:0] v);
    check(handshakeAck, 1'b1);
    parallelByte = v;
    periphStrobes = '{1'b0, 1'b0, 1'b1, 1'b1};
    repeat (4) @(negedge clk);
    periphStrobes = '{1'b1, 1'b1, 1'b1, 1'b0};
    repeat (6) @(negedge clk);
    check(handshakeAck, 1'b0);
  endtask

  // config clock pulses until ready returns; optionally follows the previous byte
  task automatic busy_count(output int n, input logic [7:0] prev, input bit follow);
    n = 0;
    while (handshakeAck !== 1'b1) begin
      pulse(1, 4);
      n++;
      if (follow && n <= 7) check(serialChainOut, prev[7 - n]);
      if (n > 12) begin
        mismatches++;
        wrap_up();
      end
    end
  endtask

  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  task automatic async_run();
    int n1;
    int n2;
    peripheralMode = MODE_ASYNC;
    clearN = 1'b1;
    repeat (6) @(negedge clk);
    write_byte(8'hc5);
    busy_count(n1, 8'hff, 1'b0);
    check(n1, 2);
    check(serialChainOut, 1'b1);
    write_byte(8'h6a);
    busy_count(n2, 8'hc5, 1'b1);
    check(n2 > n1 && n2 <= 9, 1'b1);
    check(serialChainOut, 1'b0);
    for (int i = 6; i >= 0; i--) begin
      pulse(1, 4);
      check(serialChainOut, 8'h6a >> i & 8'h01);
    end
    clearN = 1'b0;
    peripheralMode = MODE_NONE;
    repeat (6) @(negedge clk);
  endtask

  task automatic sync_run();
    logic [15:0] bytes;
    bytes = 16'ha53c;
    peripheralMode = MODE_SYNC;
    parallelByte = bytes[15:8];
    clearN = 1'b1;
    repeat (6) @(negedge clk);
    for (int p = 1; p <= 17; p++) begin
      pulse(1, 4);
      check(handshakeAck, p == 2 || p == 10);
      if (p >= 2) check(serialChainOut, bytes[17 - p]);
      if (p == 2) parallelByte = bytes[7:0];
    end
    clearN = 1'b0;
    peripheralMode = MODE_NONE;
    repeat (6) @(negedge clk);
  endtask

  task automatic readback_run();
    logic [10:0] crc;
    logic d;
    crc = '0;
    trig = 1'b1;
    repeat (6) @(negedge clk);
    pulse(0, 4);
    check(readbackInProgress, 1'b1);
    for (int i = 0; i < DUMMY_BITS; i++) begin
      pulse(0, 4);
      check({readbackInProgress, readbackSerialOut}, 2'b11);
    end
    for (int f = 0; f < FC; f++) begin
      pulse(0, 4);
      check({readbackInProgress, readbackSerialOut}, 2'b10);
      for (int b = 0; b < FB; b++) begin
        // forced high lead and tail bits
        d = (f[0] ^ b[0] ^ b[2]) | (f == 0 && b < 2) | (f == FC - 1 && b >= FB - 7);
        pulse(0, 4);
        check({readbackInProgress, readbackSerialOut}, {1'b1, d});
        crc = {crc[9:0], 1'b0} ^ ((crc[10] ^ d) ? POLY : 11'h000);
      end
      for (int c = 0; c < CHECK_BITS; c++) begin
        pulse(0, 4);
        check(readbackSerialOut, 1'b1);
      end
    end
    pulse(0, 4);
    check(readbackSerialOut, 1'b0);
    for (int k = CRC_BITS - 1; k >= 0; k--) begin
      pulse(0, 4);
      check({readbackInProgress, readbackSerialOut}, {1'b1, crc[k]});
    end
    trig = 1'b0;
    pulse(0, 4);
    check({readbackInProgress, readbackSerialOut}, 2'b01);
  endtask

  task automatic jtag_run();
    logic [4:0] bits;
    bits = 5'b10110;
    frameLengthTarget = 24'h000005;
    scanLoadActive = 1'b1;
    clearN = 1'b1;
    repeat (6) @(negedge clk);
    for (int i = 1; i <= 5; i++) begin
      tdi = bits[i - 1];
      pulse(2, 4);
      check(frameLengthTally, 24'(i));
      check({lengthReached, jtagBit}, {i == 5, bits[i - 1]});
    end
    scanLoadActive = 1'b0;
    pulse(2, 4);
    check(frameLengthTally, 24'h000005);
    check(validSeen, 5);
    clearN = 1'b0;
    repeat (6) @(negedge clk);
    check({frameLengthTally, lengthReached}, 25'h0000000);
  endtask

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    check({readbackSerialOut, serialChainOut, handshakeAck}, 3'b110);
    async_run();
    sync_run();
    readback_run();
    jtag_run();
    wrap_up();
  end
endmodule
